// >>> logic/ecd_defines.svh
// Constants for the E1 channel diagnostics, jitter attenuator and high-Z control
`ifndef ECD_DEFINES_SVH
`define ECD_DEFINES_SVH
// Clock rate and times
`define ECD_CLK_MHZ 200
`define ECD_MCLK_LOSS_US 1000
`define ECD_MCLK_LOSS_CYC (`ECD_MCLK_LOSS_US * `ECD_CLK_MHZ)
`define ECD_HWRST_NS 2000
`define ECD_HWRST_CYC ((`ECD_HWRST_NS * `ECD_CLK_MHZ + 999) / 1000)
`define ECD_TCLK_LOSS_TICKS 8'h40
// Transmit configuration fields
`define ECD_TXCFG_OE 6
`define ECD_TXCFG_OC_SEL 4
// Channel configuration fields
`define ECD_CHCFG_SOFT_RST 1
// Attenuator configuration fields
`define ECD_DJ_EN 3
`define ECD_DJ_GUARD 4
`define ECD_DJ_DEPTH_HI 2
`define ECD_DJ_DEPTH_LO 1
`define ECD_DJ_BW 0
`define ECD_DJ_DEPTH_32 8'h20
`define ECD_DJ_DEPTH_64 8'h40
`define ECD_DJ_DEPTH_128 8'h80
`define ECD_DJ_GUARD_BITS 8'h02
`define ECD_DJ_WIDE_THR 16'h0100
`define ECD_DJ_NARROW_THR 16'h0800
// Status and mask fields
`define ECD_ST_LINE_ZRUN 2
`define ECD_ST_LINE_VIOL 4
`define ECD_ST_SYS_VIOL 5
`define ECD_ST_RX_DJ 5
`define ECD_ST_TX_DJ 6
// Error control fields
`define ECD_ERR_INSERT 6
`define ECD_ERR_ZDEF 7
// Zero-run limits, ANSI and FCC alike for E1
`define ECD_ZRUN_AMI 5'h0F
`define ECD_ZRUN_B8ZS 5'h07
`define ECD_ZRUN_HDB3 5'h03
`endif

// >>> logic/ecd_pkg.sv
// Types shared by the E1 channel logic
package ecd_pkg;
   typedef enum logic [1:0] {ECD_AMI, ECD_B8ZS, ECD_HDB3} ecd_line_code_type;
   typedef enum logic [1:0] {ECD_SINGLE_NRZ, ECD_DUAL_NRZ, ECD_DUAL_RZ} ecd_tx_format_type;
   typedef struct packed {
      logic pos;
      logic neg;
   } ecd_rail_type;
   typedef struct packed {
      logic violation;
      logic zeroRun;
   } ecd_mon_event_type;
   typedef enum {ECD_DJ_FILL, ECD_DJ_RUN} ecd_dj_state_type;
endpackage

// >>> logic/ecd_channel.sv
// One E1 channel: transmit high-Z control, jitter attenuators and line monitors
// Behaviour
// (RULE_01) Global enable pin low tri-states all drivers
// (RULE_02) Master clock idle over 1 ms tri-states
// (RULE_03) Any reset kind tri-states the drivers
// (RULE_04) Channel output-enable bit zero tri-states channel
// (RULE_05) Transmit clock idle 64 ticks tri-states channel
// (RULE_06) Power down or channel reset tri-states
// (RULE_07) Over-current with option bit tri-states channel
// (RULE_08) Separate enables for receive and transmit attenuators
// (RULE_09) Depth field picks 32, 64, 128 bits
// (RULE_10) Bandwidth bit picks loop corner frequency
// (RULE_11) First-order loop gives 20 dB/decade roll-off
// (RULE_12) FIFO slip sets attenuator flag, masked request
// (RULE_13) Guard option speeds/slows within 2 bits
// (RULE_14) Monitor both paths, not single-rail transmit
// (RULE_15) Same-polarity successive marks are bipolar violations
// (RULE_16) Same-polarity successive violations are code violations
// (RULE_17) Receive violation sets line violation flag
// (RULE_18) Transmit violation sets system violation flag
// (RULE_19) Insert bit adds one violation, then clears
// (RULE_20) Zero-run limits 15, 7, 3 by code
// (RULE_21) Single-rail transmit uses the AMI zero limit
// (RULE_22) Receive zero run sets line zero-run flag
// (RULE_23) Shared request is OR of unmasked flags
`timescale 1ns/10ps
`include "ecd_defines.svh"

// ****************************************
// Jitter attenuator: FIFO drained by a slipping line tick
// ****************************************
module ecd_dejitter
   import ecd_pkg::*;
#(
   parameter int DEPTH_MAX = 128,
   parameter int AW = 7
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] cfg,
   input wire logic lineTick,
   input wire logic inStrobe,
   input wire ecd_rail_type inData,
   output ecd_rail_type outData,
   output logic outStrobe,
   output logic slip
);
   ecd_rail_type mem_q [DEPTH_MAX];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [7:0] fill_q;
   logic [7:0] depth;
   logic [7:0] cfgPrev_q;
   logic signed [15:0] errAcc_q;
   logic signed [15:0] thr;
   logic extra_q;
   logic skip_q;
   logic doRead;
   logic doWrite;
   logic full;
   logic empty;
   logic [AW-1:0] ptrMask;
   ecd_dj_state_type state_q;

   // Depth and loop bandwidth selection
   always_comb begin
      case (cfg[`ECD_DJ_DEPTH_HI:`ECD_DJ_DEPTH_LO])
         2'b00: depth = `ECD_DJ_DEPTH_32; // see (RULE_09)
         2'b01: depth = `ECD_DJ_DEPTH_64;
         default: depth = `ECD_DJ_DEPTH_128;
      endcase
      thr = cfg[`ECD_DJ_BW] ? `ECD_DJ_NARROW_THR : `ECD_DJ_WIDE_THR; // see (RULE_10)
   end
   assign ptrMask = AW'(depth - 8'h01);
   assign full = (fill_q == depth);
   assign empty = (fill_q == 8'h00);
   assign doWrite = cfg[`ECD_DJ_EN] && inStrobe;
   assign doRead = (state_q == ECD_DJ_RUN) && ((lineTick && !skip_q) || extra_q);

   // Fill phase centres the FIFO, giving a typical delay of half the depth
   always_ff @(posedge clk) begin
      cfgPrev_q <= cfg;
      if (!rst_n || cfgPrev_q != cfg) begin
         state_q <= ECD_DJ_FILL;
      end else if (state_q == ECD_DJ_FILL && fill_q >= (depth >> 1)) begin
         state_q <= ECD_DJ_RUN;
      end
   end

   // Storage and pointers
   always_ff @(posedge clk) begin
      if (!rst_n || cfgPrev_q != cfg) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         fill_q <= 8'h00;
      end else begin
         if (doWrite && (!full || doRead)) begin
            mem_q[wrPtr_q] <= inData;
            wrPtr_q <= (wrPtr_q + AW'(1)) & ptrMask;
         end
         if (doRead && !empty) begin
            rdPtr_q <= (rdPtr_q + AW'(1)) & ptrMask;
         end
         fill_q <= fill_q + 8'((doWrite && (!full || doRead)) ? 1 : 0) - 8'((doRead && !empty) ? 1 : 0);
      end
   end

   // Integrating phase loop: a first-order slip gives a single-pole roll-off
   always_ff @(posedge clk) begin
      if (!rst_n || state_q != ECD_DJ_RUN) begin
         errAcc_q <= 16'sh0000;
         extra_q <= 1'b0;
         skip_q <= 1'b0;
      end else if (lineTick) begin
         extra_q <= 1'b0;
         skip_q <= 1'b0;
         if (cfg[`ECD_DJ_GUARD] && fill_q + `ECD_DJ_GUARD_BITS >= depth) begin
            extra_q <= 1'b1; // see (RULE_13)
         end else if (cfg[`ECD_DJ_GUARD] && fill_q <= `ECD_DJ_GUARD_BITS) begin
            skip_q <= 1'b1; // see (RULE_13)
         end else if (errAcc_q > thr) begin
            extra_q <= 1'b1; // see (RULE_11)
            errAcc_q <= errAcc_q - thr;
         end else if (errAcc_q < -thr) begin
            skip_q <= 1'b1; // see (RULE_11)
            errAcc_q <= errAcc_q + thr;
         end else begin
            errAcc_q <= errAcc_q + 16'($signed({1'b0, fill_q})) - 16'($signed({1'b0, depth >> 1}));
         end
      end else begin
         extra_q <= 1'b0;
      end
   end

   // Output stage; bypass passes the input straight on
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outData <= '0;
         outStrobe <= 1'b0;
         slip <= 1'b0;
      end else if (!cfg[`ECD_DJ_EN]) begin
         outData <= inData; // see (RULE_08)
         outStrobe <= inStrobe;
         slip <= 1'b0;
      end else begin
         outData <= (doRead && !empty) ? mem_q[rdPtr_q] : '0;
         outStrobe <= doRead;
         slip <= (doRead && empty) || (doWrite && full && !doRead); // see (RULE_12)
      end
   end
endmodule

// ****************************************
// Violation and zero-run monitor for one path
// ****************************************
module ecd_violation_mon
   import ecd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic tick,
   input wire ecd_rail_type rail,
   input wire ecd_line_code_type lineCode,
   input wire logic forceAmi,
   input wire logic zeroDef,
   output ecd_mon_event_type event_q
);
   logic lastMarkPos_q;
   logic haveMark_q;
   logic lastBpvPos_q;
   logic haveBpv_q;
   logic [4:0] zeroRun_q;
   logic [4:0] limit;
   logic mark;
   logic bpv;

   // FCC and ANSI share the same E1 limits
   always_comb begin
      if (forceAmi || lineCode == ECD_AMI) begin
         limit = zeroDef ? `ECD_ZRUN_AMI : `ECD_ZRUN_AMI; // see (RULE_20) (RULE_21)
      end else if (lineCode == ECD_B8ZS) begin
         limit = `ECD_ZRUN_B8ZS;
      end else begin
         limit = `ECD_ZRUN_HDB3;
      end
   end
   assign mark = rail.pos ^ rail.neg;
   assign bpv = mark && haveMark_q && (rail.pos == lastMarkPos_q); // see (RULE_15)

   // Polarity memory and event detection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lastMarkPos_q <= 1'b0;
         haveMark_q <= 1'b0;
         lastBpvPos_q <= 1'b0;
         haveBpv_q <= 1'b0;
         zeroRun_q <= 5'h00;
         event_q <= '0;
      end else if (tick) begin
         event_q <= '0;
         if (mark) begin
            lastMarkPos_q <= rail.pos;
            haveMark_q <= 1'b1;
            zeroRun_q <= 5'h00;
         end else if (zeroRun_q <= limit) begin
            zeroRun_q <= zeroRun_q + 5'h01;
            event_q.zeroRun <= (zeroRun_q == limit); // see (RULE_20)
         end
         if (bpv && enable) begin // zero runs still counted when off
            lastBpvPos_q <= rail.pos;
            haveBpv_q <= 1'b1;
            if (lineCode == ECD_AMI && !forceAmi) begin
               event_q.violation <= 1'b1; // see (RULE_14)
            end else begin
               // Substitutions alternate their violations, so a repeat breaks the code
               event_q.violation <= haveBpv_q && (rail.pos == lastBpvPos_q); // see (RULE_16)
            end
         end
      end else begin
         event_q <= '0;
      end
   end
endmodule

// ****************************************
// Channel top
// ****************************************
module ecd_channel
   import ecd_pkg::*;
#(
   parameter int MCLK_LOSS_CYC = `ECD_MCLK_LOSS_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic masterClock,
   input wire logic derivedLineRateClock,
   input wire logic txSystemClock,
   input wire ecd_rail_type txSystemData,
   input wire logic globalOutEnable,
   input wire logic hwResetPin_n,
   input wire logic overcurrentDetect,
   input wire logic globalSoftReset,
   input wire logic [7:0] txConfigReg,
   input wire logic [7:0] channelConfigReg,
   input wire logic txPowerDown,
   input wire ecd_tx_format_type txFormat,
   input wire ecd_line_code_type lineCode,
   input wire logic remoteLoopback,
   input wire logic internalPatternXclk,
   input wire logic [7:0] rxDejitterConfig,
   input wire logic [7:0] txDejitterConfig,
   input wire logic [7:0] errorControl,
   input wire logic violationInsertWrite,
   input wire logic rxStrobe,
   input wire ecd_rail_type rxRail,
   input wire logic [7:0] maskRegTwo,
   input wire logic [7:0] maskRegZero,
   input wire logic [7:0] clearRegTwo,
   input wire logic [7:0] clearRegZero,
   input wire logic requestChain_n,
   output logic lineOutTip,
   output logic lineOutTipOe,
   output logic lineOutRing,
   output logic lineOutRingOe,
   output ecd_rail_type rxOutRail,
   output logic rxOutStrobe,
   output logic violationInsert,
   output logic [7:0] statusFlagsRegTwo,
   output logic [7:0] statusFlagsRegZero,
   output logic request_n
);
   logic [6:0] pinMeta_q;
   logic [6:0] pinSync_q;
   logic [1:0] clkPrev_q;
   logic [17:0] mclkIdle_q;
   logic [10:0] hwLow_q;
   logic [7:0] tclkIdle_q;
   logic amiNextPos_q;
   logic lastOutPos_q;
   logic txInStrobe_q;
   ecd_rail_type txInRail_q;
   logic xclkTick;
   logic tclkRise;
   logic tclkEdge;
   logic mclkLost;
   logic hwResetLong;
   logic tclkLost;
   logic hiZ;
   logic insertDone;
   ecd_rail_type txDjRail;
   logic txDjStrobe;
   logic rxSlip;
   logic txSlip;
   ecd_mon_event_type rxEvent;
   ecd_mon_event_type txEvent;

   // Pin synchronisers; second stage only is read by logic
   always_ff @(posedge clk) begin
      pinMeta_q <= {overcurrentDetect, hwResetPin_n, globalOutEnable, txSystemData, txSystemClock,
                    derivedLineRateClock};
      pinSync_q <= pinMeta_q;
      clkPrev_q <= pinSync_q[1:0];
   end
   assign xclkTick = pinSync_q[0] && !clkPrev_q[0];
   assign tclkRise = pinSync_q[1] && !clkPrev_q[1];
   assign tclkEdge = pinSync_q[1] ^ clkPrev_q[1];

   // Master clock activity, sampled through its own two stages
   logic [1:0] mclkSync_q;
   logic mclkPrev_q;
   always_ff @(posedge clk) begin
      mclkSync_q <= {mclkSync_q[0], masterClock};
      mclkPrev_q <= mclkSync_q[1];
      if (!rst_n || mclkSync_q[1] != mclkPrev_q) begin
         mclkIdle_q <= 18'h00000;
      end else if (mclkIdle_q <= 18'(MCLK_LOSS_CYC)) begin
         mclkIdle_q <= mclkIdle_q + 18'h00001;
      end
   end
   assign mclkLost = (mclkIdle_q > 18'(MCLK_LOSS_CYC)); // see (RULE_02)

   // Hardware reset pin held low beyond the qualifying time
   always_ff @(posedge clk) begin
      if (!rst_n || pinSync_q[5]) begin
         hwLow_q <= 11'h000;
      end else if (hwLow_q <= 11'(`ECD_HWRST_CYC)) begin
         hwLow_q <= hwLow_q + 11'h001;
      end
   end
   assign hwResetLong = (hwLow_q > 11'(`ECD_HWRST_CYC)); // see (RULE_03)

   // Transmit clock loss, counted in line-rate ticks
   always_ff @(posedge clk) begin
      if (!rst_n || tclkEdge) begin
         tclkIdle_q <= 8'h00;
      end else if (xclkTick && tclkIdle_q <= `ECD_TCLK_LOSS_TICKS) begin
         tclkIdle_q <= tclkIdle_q + 8'h01;
      end
   end
   // Loopback and internal patterns run on the line-rate clock, so no loss there
   assign tclkLost = (tclkIdle_q > `ECD_TCLK_LOSS_TICKS) && !remoteLoopback && !internalPatternXclk &&
                     (txFormat == ECD_SINGLE_NRZ || txFormat == ECD_DUAL_NRZ); // see (RULE_05)

   // ****************************************
   // Transmit data capture
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txInRail_q <= '0;
         txInStrobe_q <= 1'b0;
         amiNextPos_q <= 1'b1;
      end else begin
         txInStrobe_q <= tclkRise && !txPowerDown;
         if (tclkRise && txFormat == ECD_SINGLE_NRZ) begin
            // Single-rail data is marked with alternating polarity
            txInRail_q <= {pinSync_q[3] && amiNextPos_q, pinSync_q[3] && !amiNextPos_q};
            amiNextPos_q <= amiNextPos_q ^ pinSync_q[3];
         end else if (tclkRise) begin
            txInRail_q <= pinSync_q[3:2];
         end
      end
   end

   // Attenuators, one per direction
   ecd_dejitter rxDj (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(rxDejitterConfig),
      .lineTick(xclkTick),
      .inStrobe(rxStrobe),
      .inData(rxRail),
      .outData(rxOutRail),
      .outStrobe(rxOutStrobe),
      .slip(rxSlip)
   );
   ecd_dejitter txDj (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(txDejitterConfig),
      .lineTick(xclkTick),
      .inStrobe(txInStrobe_q),
      .inData(txInRail_q),
      .outData(txDjRail),
      .outStrobe(txDjStrobe),
      .slip(txSlip)
   );

   // Monitors; transmit violation checks are off for single-rail input, zero runs still counted
   ecd_violation_mon rxMon (
      .clk(clk),
      .rst_n(rst_n),
      .enable(1'b1),
      .tick(rxStrobe),
      .rail(rxRail),
      .lineCode(lineCode),
      .forceAmi(1'b0),
      .zeroDef(errorControl[`ECD_ERR_ZDEF]),
      .event_q(rxEvent)
   );
   ecd_violation_mon txMon (
      .clk(clk),
      .rst_n(rst_n),
      .enable(txFormat != ECD_SINGLE_NRZ), // see (RULE_14)
      .tick(txInStrobe_q),
      .rail(txInRail_q),
      .lineCode(lineCode),
      .forceAmi(txFormat == ECD_SINGLE_NRZ), // see (RULE_21)
      .zeroDef(errorControl[`ECD_ERR_ZDEF]),
      .event_q(txEvent)
   );

   // ****************************************
   // Line driver and violation insertion
   // ****************************************
   assign insertDone = violationInsert && txDjStrobe && (txDjRail.pos ^ txDjRail.neg);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         violationInsert <= 1'b0;
      end else if (violationInsertWrite && errorControl[`ECD_ERR_INSERT]) begin
         violationInsert <= 1'b1; // a new write wins over completion
      end else if (insertDone) begin
         violationInsert <= 1'b0; // see (RULE_19)
      end
   end

   assign hiZ = !pinSync_q[4] || mclkLost || hwResetLong || globalSoftReset || // see (RULE_01) (RULE_03)
                !txConfigReg[`ECD_TXCFG_OE] || tclkLost || txPowerDown || // see (RULE_04) (RULE_06)
                channelConfigReg[`ECD_CHCFG_SOFT_RST] || // see (RULE_06)
                (txConfigReg[`ECD_TXCFG_OC_SEL] && pinSync_q[6]); // see (RULE_07)

   // Power-on reset holds the drivers off
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineOutTip <= 1'b0;
         lineOutRing <= 1'b0;
         lineOutTipOe <= 1'b0; // see (RULE_03)
         lineOutRingOe <= 1'b0;
         lastOutPos_q <= 1'b0;
      end else begin
         lineOutTipOe <= !hiZ;
         lineOutRingOe <= !hiZ;
         if (txDjStrobe && insertDone) begin
            // Repeat the previous polarity to form the violation
            lineOutTip <= lastOutPos_q; // see (RULE_19)
            lineOutRing <= !lastOutPos_q;
         end else if (txDjStrobe) begin
            lineOutTip <= txDjRail.pos;
            lineOutRing <= txDjRail.neg;
            if (txDjRail.pos ^ txDjRail.neg) begin
               lastOutPos_q <= txDjRail.pos;
            end
         end
      end
   end

   // ****************************************
   // Sticky status flags and shared request
   // ****************************************
   // Events set over a same-cycle clear so none is lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         statusFlagsRegTwo <= 8'h00;
         statusFlagsRegZero <= 8'h00;
      end else begin
         statusFlagsRegTwo <= (statusFlagsRegTwo & ~clearRegTwo) |
            (8'(rxEvent.violation) << `ECD_ST_LINE_VIOL) | // see (RULE_17)
            (8'(txEvent.violation) << `ECD_ST_SYS_VIOL) | // see (RULE_18)
            (8'(rxEvent.zeroRun) << `ECD_ST_LINE_ZRUN); // see (RULE_22)
         statusFlagsRegZero <= (statusFlagsRegZero & ~clearRegZero) |
            (8'(rxSlip) << `ECD_ST_RX_DJ) | (8'(txSlip) << `ECD_ST_TX_DJ); // see (RULE_12)
      end
   end

   // Chained request so channels share one active-low line
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         request_n <= 1'b1;
      end else begin
         request_n <= !(|(statusFlagsRegTwo & maskRegTwo) || |(statusFlagsRegZero & maskRegZero) ||
                        !requestChain_n); // see (RULE_23)
      end
   end
endmodule

// >>> test/ecd_framer_model.sv
// Behavioural framer driving the channel transmit clock and dual-rail data
`timescale 1ns/10ps
module ecd_framer_model
   import ecd_pkg::*;
(
   input wire logic run,
   input wire logic sameMark,
   output logic txClock,
   output ecd_rail_type txData
);
   // ****************************************
   // Clock and alternating marks
   // ****************************************
   // Clock holds its last level while run is low; data moves on the falling edge, away from the sampling rise
   initial begin
      txClock = 1'b0;
      txData = 2'b10;
      forever begin
         #32;
         if (run) begin
            txClock = ~txClock;
         end
         if (run && !txClock && !sameMark) begin
            txData = {txData.neg, txData.pos};
         end
      end
   end
endmodule

// >>> test/ecd_channel_monitor.sv
// Concurrent checks on the E1 channel ports
`timescale 1ns/10ps
module ecd_channel_monitor
   import ecd_pkg::*;
#(
   parameter int MCLK_LOSS_CYC = 200
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic globalOutEnable,
   input wire logic overcurrentDetect,
   input wire logic globalSoftReset,
   input wire logic [7:0] txConfigReg,
   input wire logic [7:0] channelConfigReg,
   input wire logic txPowerDown,
   input wire logic [7:0] rxDejitterConfig,
   input wire logic rxStrobe,
   input wire ecd_rail_type rxRail,
   input wire logic [7:0] maskRegTwo,
   input wire logic [7:0] maskRegZero,
   input wire logic [7:0] clearRegTwo,
   input wire logic requestChain_n,
   input wire logic lineOutTipOe,
   input wire logic lineOutRingOe,
   input wire ecd_rail_type rxOutRail,
   input wire logic rxOutStrobe,
   input wire logic [7:0] statusFlagsRegTwo,
   input wire logic [7:0] statusFlagsRegZero,
   input wire logic request_n
);
   // ****************************************
   // Port properties
   // ****************************************
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_oe_pair: assert property (lineOutTipOe == lineOutRingOe)
      else $error("tip and ring enables differ");
   a_cfg_oe_off: assert property (!txConfigReg[6] |=> !lineOutTipOe)
      else $error("driver on with enable bit clear");
   a_soft_rst_hiz: assert property (channelConfigReg[1] |=> !lineOutTipOe)
      else $error("driver on during channel reset");
   a_pdown_hiz: assert property (txPowerDown |=> !lineOutTipOe)
      else $error("driver on during power down");
   a_gsoft_hiz: assert property (globalSoftReset |=> !lineOutTipOe)
      else $error("driver on during global reset");
   a_global_oe_hiz: assert property (!globalOutEnable [*3] |=> !lineOutTipOe)
      else $error("driver on with global enable low");
   a_oc_hiz: assert property ((overcurrentDetect && txConfigReg[4]) [*3] |=> !lineOutTipOe)
      else $error("driver on during over-current");
   a_flag_request: assert property (statusFlagsRegTwo[4] && maskRegTwo[4] |=> !request_n)
      else $error("unmasked violation flag without request");
   a_request_idle: assert property (requestChain_n && (statusFlagsRegTwo & maskRegTwo & 8'h34) == 8'h00
      && (statusFlagsRegZero & maskRegZero & 8'h60) == 8'h00 |=> request_n)
      else $error("request without unmasked flag");
   a_rx_bypass: assert property (!rxDejitterConfig[3] && rxStrobe
      |=> rxOutStrobe && rxOutRail == $past(rxRail))
      else $error("bypass copy missing");
   a_flag_sticky: assert property (statusFlagsRegTwo[2] && !clearRegTwo[2] |=> statusFlagsRegTwo[2])
      else $error("zero-run flag dropped without clear");
endmodule

bind ecd_channel ecd_channel_monitor #(.MCLK_LOSS_CYC(MCLK_LOSS_CYC)) uMon (.clk, .rst_n, .globalOutEnable,
   .overcurrentDetect, .globalSoftReset, .txConfigReg, .channelConfigReg, .txPowerDown, .rxDejitterConfig,
   .rxStrobe, .rxRail, .maskRegTwo, .maskRegZero, .clearRegTwo, .requestChain_n, .lineOutTipOe,
   .lineOutRingOe, .rxOutRail, .rxOutStrobe, .statusFlagsRegTwo, .statusFlagsRegZero, .request_n);

// >>> test/test_ecd_channel.sv
// Self-checking bench for the E1 channel high-Z, monitor and attenuator logic
`timescale 1ns/10ps
module test_ecd_channel;
   import ecd_pkg::*;
   // ****************************************
   // Signals, clocks and instances
   // ****************************************
   logic clk = 1'b0, rst_n = 1'b0, mclk = 1'b0, derived_line_rate_clock = 1'b0, mclkRun = 1'b1, tclkRun = 1'b1, same = 1'b0;
   logic gOe = 1'b1, hwRst_n = 1'b1, oc = 1'b0, gSoft = 1'b0, pDown = 1'b0, rLoop = 1'b0, insWr = 1'b0;
   logic rxStb = 1'b0, tclk, tip, tipOe, ring, ringOe, rxOutStb, ins, req_n, pTip;
   logic [7:0] txCfg = 8'h50, chCfg = 8'h00, rxDj = 8'h00, errCtl = 8'h00, mask2 = 8'h00, mask0 = 8'h00;
   logic [7:0] clr2 = 8'h00, clr0 = 8'h00, st2, st0;
   ecd_line_code_type code = ECD_AMI;
   ecd_rail_type rxR = 2'b00, txD, rxOut;
   int miscompares = 0, nCompared = 0;
   int lim [3] = '{15, 7, 3};
   // Free-running clk and line-rate clock, mclk paused while mclkRun is low; the line-rate clock has no phase tie to clk
   initial forever #2.5 clk = ~clk;
   initial forever #10 if (mclkRun) mclk = ~mclk;
   initial forever #32 derived_line_rate_clock = ~derived_line_rate_clock;
   ecd_framer_model frm (.run(tclkRun), .sameMark(same), .txClock(tclk), .txData(txD));
   ecd_channel #(.MCLK_LOSS_CYC(200)) dut (.clk, .rst_n, .masterClock(mclk), .derivedLineRateClock(derived_line_rate_clock),
      .txSystemClock(tclk), .txSystemData(txD), .globalOutEnable(gOe), .hwResetPin_n(hwRst_n),
      .overcurrentDetect(oc), .globalSoftReset(gSoft), .txConfigReg(txCfg), .channelConfigReg(chCfg),
      .txPowerDown(pDown), .txFormat(ECD_DUAL_NRZ), .lineCode(code), .remoteLoopback(rLoop),
      .internalPatternXclk(1'b0), .rxDejitterConfig(rxDj), .txDejitterConfig(8'h00), .errorControl(errCtl),
      .violationInsertWrite(insWr), .rxStrobe(rxStb), .rxRail(rxR), .maskRegTwo(mask2), .maskRegZero(mask0),
      .clearRegTwo(clr2), .clearRegZero(clr0), .requestChain_n(1'b1), .lineOutTip(tip), .lineOutTipOe(tipOe),
      .lineOutRing(ring), .lineOutRingOe(ringOe), .rxOutRail(rxOut), .rxOutStrobe(rxOutStb),
      .violationInsert(ins), .statusFlagsRegTwo(st2), .statusFlagsRegZero(st0), .request_n(req_n));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One received bit; rails turn over between strobes so stale values never look valid
   task automatic rxBit(input ecd_rail_type r);
      @(negedge clk);
      rxStb = 1'b1;
      rxR = r;
      @(negedge clk);
      rxStb = 1'b0;
      rxR = ~r;
   endtask
   task automatic clear2();
      @(negedge clk);
      clr2 = 8'hFF;
      @(negedge clk);
      clr2 = 8'h00;
   endtask
   // Cases 8 and 9 stop the framer clock; 9 adds loopback, which exempts it
   task automatic setCond(input int i, input logic on);
      if (i >= 8) tclkRun = ~on;
      case (i)
         0: txCfg[6] = ~on;
         1: chCfg[1] = on;
         2: pDown = on;
         3: gSoft = on;
         4: gOe = ~on;
         5: oc = on;
         6: hwRst_n = ~on;
         7: mclkRun = ~on;
         9: rLoop = on;
         default: ;
      endcase
   endtask
   task automatic final_report();
      $display("compared %0d miscompares %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      cyc(10);
      check("oe in reset", {6'h00, tipOe, ringOe}, 8'h00);
      rst_n = 1'b1;
      cyc(50);
      check("oe enabled", {6'h00, tipOe, ringOe}, 8'h03);
      errCtl = 8'h40;
      insWr = 1'b1;
      @(negedge clk);
      insWr = 1'b0;
      check("insert pending", {7'h00, ins}, 8'h01);
      for (int k = 0; k < 400 && ins !== 1'b0; k++) begin
         pTip = tip;
         cyc(1);
      end
      check("insert done", {7'h00, ins}, 8'h00);
      check("inserted mark", {6'h00, tip, ring}, {6'h00, pTip, !pTip});
      mask2 = 8'h34;
      same = 1'b1;
      cyc(100);
      check("tx violation", st2 & 8'h20, 8'h20);
      same = 1'b0;
      cyc(100);
      clear2();
      rxBit(2'b10);
      rxBit(2'b01);
      cyc(2);
      check("alternating marks", st2 & 8'h10, 8'h00);
      rxBit(2'b01);
      cyc(2);
      check("line violation", st2 & 8'h10, 8'h10);
      check("violation request", {7'h00, req_n}, 8'h00);
      mask2 = 8'h00;
      clear2();
      cyc(2);
      check("request released", {7'h00, req_n}, 8'h01);
      mask2 = 8'h34;
      // Both zero-run definitions behave alike on E1
      for (int d = 0; d < 2; d++) begin
         for (int c = 0; c < 3; c++) begin
            errCtl = {d[0], 7'h00};
            code = ecd_line_code_type'(c);
            clear2();
            rxBit(c[0] ? 2'b10 : 2'b01);
            repeat (lim[c]) rxBit(2'b00);
            cyc(2);
            check("zero run at limit", st2 & 8'h04, 8'h00);
            rxBit(2'b00);
            cyc(2);
            check("zero run over limit", st2 & 8'h04, 8'h04);
         end
      end
      for (int i = 0; i < 10; i++) begin
         setCond(i, 1'b1);
         cyc(900);
         check("oe with cause", {6'h00, tipOe, ringOe}, {6'h00, i == 9, i == 9});
         setCond(i, 1'b0);
         cyc(60);
         check("oe restored", {6'h00, tipOe, ringOe}, 8'h03);
      end
      mask0 = 8'h60;
      rxDj = 8'h08;
      @(negedge clk);
      rxStb = 1'b1;
      cyc(300);
      rxStb = 1'b0;
      check("rx slip", st0 & 8'h20, 8'h20);
      check("slip request", {7'h00, req_n}, 8'h00);
      final_report();
   end
   // Watchdog well past the expected run of about 52 us
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
endmodule
